// *** rtl/wdt_params.svh ***
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define WDT_MODE_ADDR      16'hff98
`define WDT_KEY_ADDR       16'hff99

// ----------------------------------------------------------------------
// Values and field positions
// ----------------------------------------------------------------------
`define WDT_KEY_RESTART    8'hac
`define WDT_KEY_READ       8'h9a
`define WDT_MODE_RESET     8'h67
`define WDT_MODE_TOP       3'h3
`define WDT_STOP_BIT       4
`define WDT_SRC_BIT        3
`define WDT_CODE_MSB       2

// ----------------------------------------------------------------------
// Timing: period exponents in source ticks, strap settling in cycles
// ----------------------------------------------------------------------
`define WDT_INT_BASE_EXP   5'h0b
`define WDT_HS_BASE_EXP    5'h0d
`define WDT_COUNT_W        21
`define WDT_STRAP_SETTLE   2'h2

`endif

// *** rtl/wdt_pkg.sv ***
package wdt_pkg;

    // State of one tick synchroniser
    typedef struct packed {
        logic [1:0] syncStage;
        logic       lastLevel;
        logic       tick;
    } tick_state_t;

    // State of the watchdog core
    typedef struct packed {
        logic [1:0]  strapSync;
        logic [1:0]  strapWait;
        logic        strapDone;
        logic        fixedMode;
        logic        modeWritten;
        logic        swStopped;
        logic [4:0]  modeBits;
        logic [20:0] count;
        logic        pendingReset;
        logic        resetRequest;
        logic [7:0]  rdData;
    } wdt_state_t;

endpackage

// *** rtl/tick_if.sv ***
`timescale 1ns/1ps

// One-cycle tick pulse from a synchroniser to the counter
interface tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface

// *** rtl/tick_sync.sv ***
`timescale 1ns/1ps

module tick_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clkEnable,
    input  wire logic rawLevel,
    tick_if.source    tickOut
);
    import wdt_pkg::*;

    tick_state_t st;
    tick_state_t next_st;

    // --------------------------------------------------------------
    // Two-stage sync, then rising-edge detect on the second stage only
    // --------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.syncStage = {st.syncStage[0], rawLevel};
        next_st.lastLevel = st.syncStage[1];
        next_st.tick      = st.syncStage[1] & ~st.lastLevel;
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else if (clkEnable) begin
            st <= next_st;
        end
    end

    assign tickOut.tick = st.tick;

endmodule // tick_sync

// *** rtl/watchdog_restart_and_reset.sv ***
// Function
// - Key 0xAC clears counter, counting resumes
// - Key register resets to 0x9A
// - Wrong key raises reset, deferred if halted
// - Bit access to key raises reset
// - Key register always reads 0x9A
// - Overflow while counting raises reset
// - Second mode write resets, defers, or nothing
// - Software-stopped watchdog ignores key faults
// - Fixed mode: internal clock, never stoppable
// - After reset: internal clock, code 111
// - Fixed mode ignores clock-select bits 3,4
// - First mode register write clears the counter
// - Fixed mode keeps counting during STOP
// - Mode resets 0x67, select 00/01/1x
// - Period 2^(11+n) internal, 2^(13+n) fast
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "wdt_params.svh"

module watchdog_restart_and_reset (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clkEnable,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic        bitAccess,
    output logic      [7:0]  regRdData,
    input  wire logic        fixedOscStrap,
    input  wire logic        internalOscLevel,
    input  wire logic        highSpeedLevel,
    input  wire logic        standbyMode,
    input  wire logic        sourceClockHalted,
    input  wire logic        resetTaken,
    output logic             resetRequest,
    output logic             watchdogCounting
);
    import wdt_pkg::*;

    // ------------------------------------------------------------------
    // Reset image of the state
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = `WDT_MODE_RESET;
    localparam wdt_state_t RESET_STATE = '{
        strapSync    : 2'h0,
        strapWait    : 2'h0,
        strapDone    : 1'b0,
        fixedMode    : 1'b1,
        modeWritten  : 1'b0,
        swStopped    : 1'b0,
        modeBits     : MODE_RESET[4:0],
        count        : '0,
        pendingReset : 1'b0,
        resetRequest : 1'b0,
        rdData       : 8'h00
    };

    wdt_state_t st;
    wdt_state_t next_st;

    // ------------------------------------------------------------------
    // Source tick synchronisers
    // ------------------------------------------------------------------
    tick_if intTick ();
    tick_if hsTick ();

    tick_sync u_int_sync (
        .clk       (clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .rawLevel  (internalOscLevel),
        .tickOut   (intTick)
    );

    tick_sync u_hs_sync (
        .clk       (clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .rawLevel  (highSpeedLevel),
        .tickOut   (hsTick)
    );

    // ------------------------------------------------------------------
    // Overflow point: last count value for a code and a base exponent
    // ------------------------------------------------------------------
    function automatic logic [20:0] last_count(input logic [2:0] code,
                                               input logic [4:0] base);
        logic [4:0] expo;
        expo = base + {2'b00, code};
        return (21'h1 << expo) - 21'h1;
    endfunction

    // ------------------------------------------------------------------
    // Decoded access and clock status
    // ------------------------------------------------------------------
    logic        keyHit;
    logic        modeHit;
    logic        keyWrite;
    logic        modeWrite;
    logic        keyBitOp;
    logic        keyGood;
    logic        clockHeld;
    logic        counting;
    logic        useHighSpeed;
    logic        tickNow;
    logic [20:0] lastValue;

    // Bus decode; single-bit accesses are flagged by bitAccess
    always_comb begin
        keyHit    = (regAddr == `WDT_KEY_ADDR);
        modeHit   = (regAddr == `WDT_MODE_ADDR);
        keyWrite  = regWrite & keyHit;
        modeWrite = regWrite & modeHit & ~bitAccess;
        keyBitOp  = bitAccess & (regWrite | regRead) & keyHit;
        keyGood   = keyWrite & ~bitAccess &
                    (regWrData == `WDT_KEY_RESTART);
    end

    // Source clock status; fixed mode never halts, even in STOP
    always_comb begin
        clockHeld    = ~st.fixedMode &
                       (standbyMode | sourceClockHalted);
        counting     = ~st.swStopped & ~clockHeld;
        useHighSpeed = ~st.fixedMode &
                       st.modeBits[`WDT_SRC_BIT];
        tickNow      = useHighSpeed ? hsTick.tick : intTick.tick;
        lastValue    = useHighSpeed ?
            last_count(st.modeBits[`WDT_CODE_MSB:0], `WDT_HS_BASE_EXP) :
            last_count(st.modeBits[`WDT_CODE_MSB:0], `WDT_INT_BASE_EXP);
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic fault;
    logic raise;

    always_comb begin
        next_st = st;
        fault   = 1'b0;
        raise   = 1'b0;

        // Strap is caught only after its sync stages have filled
        next_st.strapSync = {st.strapSync[0], fixedOscStrap};
        if (!st.strapDone) begin
            if (st.strapWait == `WDT_STRAP_SETTLE) begin
                next_st.strapDone = 1'b1;
                next_st.fixedMode = st.strapSync[1];
            end else begin
                next_st.strapWait = st.strapWait + 2'h1;
            end
        end

        // Count on the selected source; halted counts hold their value
        if (counting && tickNow) begin
            if (st.count == lastValue) begin
                fault         = 1'b1;
                next_st.count = '0;
            end else begin
                next_st.count = st.count + 21'h1;
            end
        end

        // Restart key; clearing wins over a same-cycle tick
        if (keyGood && !st.swStopped) begin
            next_st.count = '0;
        end

        // Wrong key or bit access; silent once software stopped it
        if (((keyWrite && !keyGood) || keyBitOp) && !st.swStopped) begin
            fault = 1'b1;
        end
        // Mode register: one write only
        if (modeWrite) begin
            if (!st.modeWritten) begin
                next_st.modeWritten = 1'b1;
                next_st.count       = '0;
                if (st.fixedMode) begin
                    next_st.modeBits = {2'b00, regWrData[2:0]};
                end else begin
                    next_st.modeBits  = regWrData[4:0];
                    next_st.swStopped = regWrData[`WDT_STOP_BIT];
                end
            end else if (!st.swStopped) begin
                fault = 1'b1;
            end
        end

        // A fault while the source is halted waits for its return
        if (fault) begin
            if (counting) begin
                raise = 1'b1;
            end else begin
                next_st.pendingReset = 1'b1;
            end
        end
        if (st.pendingReset && !clockHeld) begin
            raise                = 1'b1;
            next_st.pendingReset = 1'b0;
        end

        // Held request; a new cause wins over the acknowledge
        next_st.resetRequest = (st.resetRequest & ~resetTaken) | raise;
        // Read data valid only in the cycle after the strobe
        next_st.rdData = 8'h00;
        if (regRead) begin
            if (keyHit) begin
                next_st.rdData = `WDT_KEY_READ;
            end else if (modeHit) begin
                next_st.rdData = {`WDT_MODE_TOP, st.modeBits};
            end
        end
    end

    // ------------------------------------------------------------------
    // State register; clock enable low freezes everything
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= RESET_STATE;
        end else if (clkEnable) begin
            st <= next_st;
        end
    end

    // Outputs
    assign regRdData        = st.rdData;
    assign resetRequest     = st.resetRequest;
    assign watchdogCounting = counting;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Key register: restart, readback and the two key faults
    a_key_restart: assert property (
        clkEnable && keyGood && !st.swStopped |=> st.count == '0
    ) else $error("restart key did not clear the count");

    a_key_readback: assert property (
        clkEnable && regRead && keyHit |=> regRdData == 8'h9a
    ) else $error("key register read not 0x9a");

    a_wrong_key: assert property (
        clkEnable && keyWrite && !bitAccess && regWrData != 8'hac &&
        !st.swStopped && counting |=> resetRequest
    ) else $error("wrong key raised no reset");

    a_bit_access: assert property (
        clkEnable && keyBitOp && !st.swStopped && counting
        |=> resetRequest
    ) else $error("bit access raised no reset");

    // Overflow and the once-only mode register
    a_overflow_reset: assert property (
        clkEnable && counting && tickNow && st.count == lastValue
        |=> resetRequest && st.count == '0
    ) else $error("overflow raised no reset");

    a_second_mode: assert property (
        clkEnable && modeWrite && st.modeWritten && !st.swStopped &&
        counting |=> resetRequest
    ) else $error("second mode write raised no reset");

    a_stopped_quiet: assert property (
        clkEnable && st.swStopped && !st.pendingReset && !resetRequest
        |=> !resetRequest
    ) else $error("stopped watchdog raised a reset");

    a_fixed_select: assert property (
        st.fixedMode |-> st.modeBits[4:3] == 2'b00 && !st.swStopped
    ) else $error("fixed mode left the internal clock");

    a_mode_clear: assert property (
        clkEnable && modeWrite && !st.modeWritten |=> st.count == '0
    ) else $error("mode write did not clear the count");

    // Causes met while the source is halted are parked, then fired
    a_deferred_fire: assert property (
        clkEnable && st.pendingReset && !clockHeld |=> resetRequest
    ) else $error("deferred reset not raised");

    a_deferred_bit: assert property (
        clkEnable && keyBitOp && !st.swStopped && clockHeld
        |=> st.pendingReset
    ) else $error("halted bit access not parked");

    a_deferred_mode: assert property (
        clkEnable && modeWrite && st.modeWritten && !st.swStopped &&
        clockHeld |=> st.pendingReset
    ) else $error("halted second mode write not parked");

    a_stop_final: assert property (
        st.swStopped |=> st.swStopped && !counting
    ) else $error("software stop was undone");

    a_request_hold: assert property (
        resetRequest && !resetTaken |=> resetRequest
    ) else $error("reset request dropped early");

    a_reset_state: assert property (
        $fell(reset) |-> st.modeBits == 5'h07 && st.count == '0 &&
        !resetRequest
    ) else $error("reset state wrong");

    // Fixed oscillator mode never stops, not even in standby
    a_fixed_counting: assert property (
        st.fixedMode |-> counting
    ) else $error("fixed mode watchdog not counting");

    a_fixed_stop: assert property (
        clkEnable && st.fixedMode && standbyMode && tickNow &&
        st.count != lastValue && !keyGood && !modeWrite
        |=> st.count == $past(st.count) + 21'h1
    ) else $error("fixed mode count stalled in standby");

    // Readback and overflow points against fixed constants
    a_mode_readback: assert property (
        clkEnable && regRead && modeHit
        |=> regRdData == {3'h3, $past(st.modeBits)}
    ) else $error("mode register readback wrong");

    a_longest_period: assert property (
        !useHighSpeed && st.modeBits[2:0] == 3'h7
        |-> lastValue == 21'h3ffff
    ) else $error("longest internal period wrong");

    a_fast_period: assert property (
        useHighSpeed && st.modeBits[2:0] == 3'h0
        |-> lastValue == 21'h01fff
    ) else $error("shortest high-speed period wrong");

    c_overflow:   cover property (counting && tickNow &&
                                  st.count == lastValue);
    c_key_good:   cover property (keyGood && st.count != '0);
    c_deferred:   cover property (st.pendingReset ##1 resetRequest);
    c_sw_stopped: cover property ($rose(st.swStopped));
    c_fast_tick:  cover property (useHighSpeed && tickNow);

endmodule // watchdog_restart_and_reset

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "wdt_params.svh"

module tb_top;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk;
    logic        reset;
    logic        clkEnable;
    logic [15:0] regAddr;
    logic [7:0]  regWrData;
    logic        regWrite;
    logic        regRead;
    logic        bitAccess;
    logic [7:0]  regRdData;
    logic        fixedOscStrap;
    logic        internalOscLevel;
    logic        highSpeedLevel;
    logic        standbyMode;
    logic        sourceClockHalted;
    logic        resetTaken;
    logic        resetRequest;
    logic        watchdogCounting;
    logic [7:0]  rdVal;
    logic [7:0]  badKey;
    int          errCount;
    int          nTests;
    int          cycles;

    watchdog_restart_and_reset dut_u (
        .clk               (clk),
        .reset             (reset),
        .clkEnable         (clkEnable),
        .regAddr           (regAddr),
        .regWrData         (regWrData),
        .regWrite          (regWrite),
        .regRead           (regRead),
        .bitAccess         (bitAccess),
        .regRdData         (regRdData),
        .fixedOscStrap     (fixedOscStrap),
        .internalOscLevel  (internalOscLevel),
        .highSpeedLevel    (highSpeedLevel),
        .standbyMode       (standbyMode),
        .sourceClockHalted (sourceClockHalted),
        .resetTaken        (resetTaken),
        .resetRequest      (resetRequest),
        .watchdogCounting  (watchdogCounting)
    );

    // Clock at 20 MHz
    always #25 clk = ~clk;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    // Expected mode readback: top bits fixed, select forced in fixed mode
    function automatic logic [7:0] modeRead(input logic [7:0] w,
                                            input logic fixed);
        return {3'h3, fixed ? 2'h0 : w[4:3], w[2:0]};
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cut a hang short; the whole run needs about 65k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errCount++;
            closeOut();
        end
    end

    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic bitOp);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        bitAccess <= bitOp;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
        bitAccess <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the read edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Source pulses, two cycles high and two low, slow enough to sync
    task automatic ticks(input int n, input logic fast);
        for (int i = 0; i < n; i++) begin
            highSpeedLevel   <= fast;
            internalOscLevel <= ~fast;
            repeat (2) @(posedge clk);
            highSpeedLevel   <= 1'b0;
            internalOscLevel <= 1'b0;
            repeat (2) @(posedge clk);
        end
        #1;
    endtask

    task automatic takeReset();
        @(posedge clk);
        resetTaken <= 1'b1;
        @(posedge clk);
        resetTaken <= 1'b0;
        #1;
        chk1(resetRequest, 1'b0);
    endtask

    // Strap is settled before release, mode writes wait four edges
    task automatic doReset(input logic strap);
        @(posedge clk);
        fixedOscStrap     <= strap;
        sourceClockHalted <= 1'b0;
        standbyMode       <= 1'b0;
        reset             <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 0; reset = 1; clkEnable = 1; regAddr = 16'h0000;
        regWrData = 8'h00; regWrite = 0; regRead = 0; bitAccess = 0;
        fixedOscStrap = 0; internalOscLevel = 0; highSpeedLevel = 0;
        standbyMode = 0; sourceClockHalted = 0; resetTaken = 0;
        errCount = 0; nTests = 0; cycles = 0;
        void'($urandom(32'h855989ed));

        // Reset values, restart key and key faults
        doReset(1'b0);
        rd(`WDT_KEY_ADDR, rdVal); chk8(rdVal, `WDT_KEY_READ);
        rd(`WDT_MODE_ADDR, rdVal); chk8(rdVal, 8'h67);
        chk1(watchdogCounting, 1'b1);
        wr(`WDT_KEY_ADDR, `WDT_KEY_RESTART, 1'b0);
        chk1(resetRequest, 1'b0);
        rd(`WDT_KEY_ADDR, rdVal); chk8(rdVal, `WDT_KEY_READ);
        do badKey = 8'($urandom); while (badKey == `WDT_KEY_RESTART);
        wr(`WDT_KEY_ADDR, badKey, 1'b0);
        chk1(resetRequest, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk1(resetRequest, 1'b1);
        takeReset();
        wr(`WDT_KEY_ADDR, `WDT_KEY_RESTART, 1'b1);
        chk1(resetRequest, 1'b1);
        takeReset();
        $display("test key_faults done");

        // Shortest period, restart in mid-count, overflow, second write
        doReset(1'b0);
        wr(`WDT_MODE_ADDR, 8'h60, 1'b0);
        rd(`WDT_MODE_ADDR, rdVal);
        chk8(rdVal, modeRead(8'h60, 1'b0));
        ticks(1000 + ($urandom % 1000), 1'b0);
        wr(`WDT_KEY_ADDR, `WDT_KEY_RESTART, 1'b0);
        ticks(2047, 1'b0);
        chk1(resetRequest, 1'b0);
        ticks(1, 1'b0);
        chk1(resetRequest, 1'b1);
        takeReset();
        wr(`WDT_MODE_ADDR, 8'h61, 1'b0);
        chk1(resetRequest, 1'b1);
        takeReset();
        $display("test overflow done");

        // Software stop hides every fault
        doReset(1'b0);
        wr(`WDT_MODE_ADDR, 8'h70, 1'b0);
        chk1(watchdogCounting, 1'b0);
        rd(`WDT_MODE_ADDR, rdVal);
        chk8(rdVal, modeRead(8'h70, 1'b0));
        wr(`WDT_KEY_ADDR, badKey, 1'b0);
        chk1(resetRequest, 1'b0);
        wr(`WDT_KEY_ADDR, `WDT_KEY_RESTART, 1'b1);
        chk1(resetRequest, 1'b0);
        wr(`WDT_MODE_ADDR, 8'h60, 1'b0);
        chk1(resetRequest, 1'b0);
        chk1(watchdogCounting, 1'b0);
        $display("test sw_stop done");

        // Faults while the source clock is stopped wait for its return
        doReset(1'b0);
        sourceClockHalted <= 1'b1;
        wr(`WDT_MODE_ADDR, 8'h67, 1'b0);
        wr(`WDT_MODE_ADDR, 8'h67, 1'b0);
        chk1(resetRequest, 1'b0);
        sourceClockHalted <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk1(resetRequest, 1'b1);
        takeReset();
        sourceClockHalted <= 1'b1;
        wr(`WDT_KEY_ADDR, badKey, 1'b0);
        chk1(resetRequest, 1'b0);
        sourceClockHalted <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk1(resetRequest, 1'b1);
        takeReset();
        $display("test deferred done");

        // Fixed oscillator: select bits ignored, counts through STOP
        doReset(1'b1);
        wr(`WDT_MODE_ADDR, 8'h78, 1'b0);
        rd(`WDT_MODE_ADDR, rdVal);
        chk8(rdVal, modeRead(8'h78, 1'b1));
        standbyMode <= 1'b1;
        @(posedge clk);
        #1 chk1(watchdogCounting, 1'b1);
        ticks(1500, 1'b0);
        wr(`WDT_KEY_ADDR, `WDT_KEY_RESTART, 1'b0);
        ticks(2047, 1'b0);
        chk1(resetRequest, 1'b0);
        ticks(1, 1'b0);
        chk1(resetRequest, 1'b1);
        takeReset();
        $display("test fixed_mode done");

        // High-speed source: mode write clears, standby holds the count
        doReset(1'b0);
        ticks(300, 1'b0);
        wr(`WDT_MODE_ADDR, 8'h68, 1'b0);
        rd(`WDT_MODE_ADDR, rdVal);
        chk8(rdVal, modeRead(8'h68, 1'b0));
        ticks(8000, 1'b1);
        standbyMode <= 1'b1;
        ticks(100, 1'b1);
        standbyMode <= 1'b0;
        ticks(191, 1'b1);
        chk1(resetRequest, 1'b0);
        ticks(1, 1'b1);
        chk1(resetRequest, 1'b1);
        takeReset();
        $display("test fast_source done");

        closeOut();
    end

endmodule // tb_top
